// ===== hw/spd_defines.vh
// constants for the serial-to-parallel high-voltage driver logic
`ifndef SPD_DEFINES_VH
`define SPD_DEFINES_VH

// shift chain and output latch width
`define SPD_NUM_STAGES 16
`define SPD_MSB 15
`define SPD_ALL_ZERO 16'h0000

// system clock period in ns
`define SPD_CLK_PERIOD_NS 8

// shortest legal shift clock period in ns
`define SPD_SHIFT_PERIOD_NS 2000
// shortest legal high or low phase of the shift clock in ns
`define SPD_PULSE_WIDTH_NS 1000

// least times round up to whole cycles
`define SPD_SHIFT_PERIOD_CYC \
  ((`SPD_SHIFT_PERIOD_NS + `SPD_CLK_PERIOD_NS - 1) / `SPD_CLK_PERIOD_NS)
`define SPD_PULSE_WIDTH_CYC \
  ((`SPD_PULSE_WIDTH_NS + `SPD_CLK_PERIOD_NS - 1) / `SPD_CLK_PERIOD_NS)

// timing counter width and saturation value
`define SPD_TCNT_W 9
`define SPD_TCNT_MAX 9'h1FF

// shift counter width for the fill tracker
`define SPD_FILL_W 5
`define SPD_FILL_FULL 5'h10

`endif

// ===== hw/spd_shift_chain.v
// sixteen-stage serial shift chain with registered stages
`timescale 1ns/10ps
`include "spd_defines.vh"

module spd_shift_chain (
  input wire clk_i,
  input wire arst_n_i,
  input wire shift_en_i,
  input wire serial_in_i,
  output wire [`SPD_MSB:0] stages_o,
  output wire [`SPD_MSB:0] stages_next_o
);

  reg [`SPD_MSB:0] stages_q;
  wire [`SPD_MSB:0] stages_d;

  ////////////////////////////////////////////////////////////////////////
  // sixteen stages
  assign stages_d[0] = shift_en_i ? serial_in_i : stages_q[0];

  genvar g;
  generate
    for (g = 1; g < `SPD_NUM_STAGES; g = g + 1)
    begin : g_stage
      assign stages_d[g] = shift_en_i ? stages_q[g-1] : stages_q[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // hold between edges
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      stages_q <= `SPD_ALL_ZERO;
    end
    else
    begin
      stages_q <= stages_d;
    end
  end

  assign stages_o = stages_q;
  assign stages_next_o = stages_d;

endmodule // spd_shift_chain

// ===== hw/spd_driver_logic.v
// control logic of a 16-channel serial-to-parallel high-voltage driver
`timescale 1ns/10ps
`include "spd_defines.vh"

// Overview of operation
// - each rising shift clock edge moves the chain one stage, input first.
// - the shift chain has exactly sixteen stages, one per output channel.
// - a stage takes its predecessor's old value and holds between edges.
// - the last stage drives the serial output for daisy chaining.
// - serial output changes only on the falling shift clock edge.
// - latch gate low makes the output latch follow the shift chain.
// - latch gate high freezes the output latch regardless of shifting.
// - outputs come from the latch combined with polarity, never the chain.
// - polarity low inverts every output; polarity high passes latch bits.
// - backplane is high when polarity low, low when high, data ignored.
module spd_driver_logic (
  input wire clk_i,
  input wire arst_n_i,
  input wire shift_clk_i,
  input wire serial_in_i,
  input wire latch_gate_n_i,
  input wire invert_select_n_i,
  output wire serial_out_o,
  output wire [`SPD_MSB:0] high_side_outputs_o,
  output wire backplane_drive_o,
  output wire contents_known_o,
  output wire shift_rate_error_o
);

  ////////////////////////////////////////////////////////////////////////
  // shift clock edge detector states
  localparam [2:0] ST_UNKNOWN = 3'h1;
  localparam [2:0] ST_LOW = 3'h2;
  localparam [2:0] ST_HIGH = 3'h4;

  localparam integer PERIOD_INT = `SPD_SHIFT_PERIOD_CYC;
  localparam integer WIDTH_INT = `SPD_PULSE_WIDTH_CYC;
  localparam [`SPD_TCNT_W-1:0] PERIOD_CYC = PERIOD_INT[`SPD_TCNT_W-1:0];
  localparam [`SPD_TCNT_W-1:0] WIDTH_CYC = WIDTH_INT[`SPD_TCNT_W-1:0];

  // output value of a channel from its latch bit and the polarity pin
  function [`SPD_MSB:0] apply_polarity;
    input [`SPD_MSB:0] latch_bits;
    input invert_n;
    begin
      apply_polarity = invert_n ? latch_bits : ~latch_bits;
    end
  endfunction

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg rise_edge;
  reg fall_edge;

  reg serial_out_q;
  reg [`SPD_MSB:0] latch_q;
  reg [`SPD_MSB:0] latch_d;
  reg [`SPD_MSB:0] outputs_q;
  reg backplane_q;
  reg [`SPD_FILL_W-1:0] fill_q;
  reg known_q;
  reg [`SPD_TCNT_W-1:0] period_cnt_q;
  reg [`SPD_TCNT_W-1:0] phase_cnt_q;
  reg period_seen_q;
  reg rate_err_q;

  wire [`SPD_MSB:0] stages;
  wire [`SPD_MSB:0] stages_next;

  ////////////////////////////////////////////////////////////////////////
  // pin is sampled as-is; the unknown state blocks a false edge after reset
  always @*
  begin
    state_d = state_q;
    rise_edge = 1'b0;
    fall_edge = 1'b0;
    case (state_q)
      ST_UNKNOWN:
      begin
        state_d = shift_clk_i ? ST_HIGH : ST_LOW;
      end
      ST_LOW:
      begin
        if (shift_clk_i)
        begin
          state_d = ST_HIGH;
          rise_edge = 1'b1;
        end
      end
      ST_HIGH:
      begin
        if (!shift_clk_i)
        begin
          state_d = ST_LOW;
          fall_edge = 1'b1;
        end
      end
      default:
      begin
        state_d = ST_UNKNOWN;
      end
    endcase
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_q <= ST_UNKNOWN;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // advance on rising edge
  spd_shift_chain u_chain (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .shift_en_i(rise_edge),
    .serial_in_i(serial_in_i),
    .stages_o(stages),
    .stages_next_o(stages_next)
  );

  ////////////////////////////////////////////////////////////////////////
  // latch uses the chain's next value so it tracks a shift in the same cycle
  always @*
  begin
    latch_d = latch_gate_n_i ? latch_q : stages_next;
  end

  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      latch_q <= `SPD_ALL_ZERO;
      outputs_q <= `SPD_ALL_ZERO;
      backplane_q <= 1'b0;
      serial_out_q <= 1'b0;
    end
    else
    begin
      latch_q <= latch_d;
      outputs_q <= apply_polarity(latch_d, invert_select_n_i);
      backplane_q <= ~invert_select_n_i;
      if (fall_edge)
      begin
        serial_out_q <= stages[`SPD_MSB];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // known after sixteen shifts latched
  // a latch with the gate held low across the fill also counts
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      fill_q <= {`SPD_FILL_W{1'b0}};
      known_q <= 1'b0;
    end
    else
    begin
      if (rise_edge && (fill_q != `SPD_FILL_FULL))
      begin
        fill_q <= fill_q + 1'b1;
      end
      if (!latch_gate_n_i && (fill_q == `SPD_FILL_FULL))
      begin
        known_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // watch host shift rate
  // flag is sticky until reset; it only reports, shifting is never blocked
  always @(posedge clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      period_cnt_q <= {`SPD_TCNT_W{1'b0}};
      phase_cnt_q <= {`SPD_TCNT_W{1'b0}};
      period_seen_q <= 1'b0;
      rate_err_q <= 1'b0;
    end
    else
    begin
      if (rise_edge)
      begin
        period_cnt_q <= {`SPD_TCNT_W{1'b0}};
        period_seen_q <= 1'b1;
      end
      else if (period_cnt_q != `SPD_TCNT_MAX)
      begin
        period_cnt_q <= period_cnt_q + 1'b1;
      end
      if (rise_edge || fall_edge)
      begin
        phase_cnt_q <= {`SPD_TCNT_W{1'b0}};
      end
      else if (phase_cnt_q != `SPD_TCNT_MAX)
      begin
        phase_cnt_q <= phase_cnt_q + 1'b1;
      end
      // counts lag the edge by one; limit less one cannot wrap at saturation
      if (rise_edge && period_seen_q &&
          (period_cnt_q < (PERIOD_CYC - 1'b1)))
      begin
        rate_err_q <= 1'b1;
      end
      if ((rise_edge || fall_edge) && period_seen_q &&
          (phase_cnt_q < (WIDTH_CYC - 1'b1)))
      begin
        rate_err_q <= 1'b1;
      end
    end
  end

  assign serial_out_o = serial_out_q;
  assign high_side_outputs_o = outputs_q;
  assign backplane_drive_o = backplane_q;
  assign contents_known_o = known_q;
  assign shift_rate_error_o = rate_err_q;

endmodule // spd_driver_logic

// ===== verification/spd_host_model.sv
// host model driving the shift clock and serial data pins
`timescale 1ns/10ps
module spd_host_model #(
  parameter PH = 130
) (
  input wire clk_i,
  output reg sclk_o,
  output reg dat_o
);
  initial
  begin
    sclk_o = 1'b0;
    dat_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // msb first, so bit 15 lands in the last stage
  task shift_word(input [15:0] w);
    integer i;
    begin
      @(posedge clk_i);
      for (i = 15; i >= 0; i = i - 1)
      begin
        sclk_o <= 1'b1;
        dat_o <= w[i];
        // phases kept above the minimum width
        repeat (PH) @(posedge clk_i);
        sclk_o <= 1'b0;
        @(posedge clk_i);
        // past hold time, so the pin shows no stale bit
        dat_o <= ~w[i];
        repeat (PH - 1) @(posedge clk_i);
      end
    end
  endtask
  // one shift clock pulse; a short phase breaks the rate limit on purpose
  task clock_pulse(input integer ph);
    begin
      @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (ph) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (ph) @(posedge clk_i);
    end
  endtask
endmodule // spd_host_model

// ===== verification/spd_checker_assertions.sv
// port checker for the serial-to-parallel driver logic
`timescale 1ns/10ps
module spd_checker (
  input wire clk_i,
  input wire arst_n_i,
  input wire shift_clk_i,
  input wire serial_in_i,
  input wire latch_gate_n_i,
  input wire invert_select_n_i,
  input wire serial_out_o,
  input wire [15:0] high_side_outputs_o,
  input wire backplane_drive_o,
  input wire contents_known_o,
  input wire shift_rate_error_o
);
  reg [1:0] up_q;
  wire ok;
  // the first edges after reset only prime the edge detector
  always @(posedge clk_i or negedge arst_n_i)
    if (!arst_n_i)
      up_q <= 2'h0;
    else
      up_q <= {up_q[0], 1'b1};
  assign ok = up_q[1];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_open_rise;
    ok && !latch_gate_n_i && !$past(latch_gate_n_i) && invert_select_n_i
      && $past(invert_select_n_i) && $rose(shift_clk_i);
  endsequence
  a_shift_one_stage: assert property (s_open_rise |=>
    high_side_outputs_o == {$past(high_side_outputs_o[14:0]),
    $past(serial_in_i)}) else $error("shift did not move one stage");
  a_idle_steady: assert property (ok && !latch_gate_n_i &&
    !$past(latch_gate_n_i) && $stable(invert_select_n_i) &&
    !$rose(shift_clk_i) |=> $stable(high_side_outputs_o))
    else $error("outputs moved without a shift");
  a_gate_holds: assert property (ok && latch_gate_n_i &&
    $past(latch_gate_n_i) && $stable(invert_select_n_i) |=>
    $stable(high_side_outputs_o)) else $error("closed latch changed");
  a_polarity_inverts: assert property (ok && latch_gate_n_i &&
    $past(latch_gate_n_i) && $changed(invert_select_n_i) |=>
    high_side_outputs_o == ~$past(high_side_outputs_o))
    else $error("polarity change did not invert outputs");
  a_backplane_polarity: assert property (ok |->
    backplane_drive_o == !$past(invert_select_n_i))
    else $error("backplane does not follow polarity");
  a_serial_out_falls: assert property (ok && $changed(serial_out_o) |->
    !$past(shift_clk_i) && $past(shift_clk_i, 2))
    else $error("serial out moved off a falling edge");
  a_serial_last_stage: assert property (ok && $fell(shift_clk_i) &&
    !$past(latch_gate_n_i) && $past(invert_select_n_i) |=>
    serial_out_o == $past(high_side_outputs_o[15]))
    else $error("serial out is not the last stage");
  a_known_sticky: assert property (ok && contents_known_o |=>
    contents_known_o) else $error("known flag dropped");
  a_rate_err_sticky: assert property (ok && shift_rate_error_o |=>
    shift_rate_error_o) else $error("rate error flag dropped");
  a_rate_err_edge: assert property (ok &&
    $rose(shift_rate_error_o) |->
    $past(shift_clk_i) != $past(shift_clk_i, 2))
    else $error("rate error set off a shift clock edge");
endmodule // spd_checker
bind spd_driver_logic spd_checker spd_checker_inst (.clk_i(clk_i),
  .arst_n_i(arst_n_i), .shift_clk_i(shift_clk_i),
  .serial_in_i(serial_in_i), .latch_gate_n_i(latch_gate_n_i),
  .invert_select_n_i(invert_select_n_i), .serial_out_o(serial_out_o),
  .high_side_outputs_o(high_side_outputs_o),
  .backplane_drive_o(backplane_drive_o),
  .contents_known_o(contents_known_o),
  .shift_rate_error_o(shift_rate_error_o));

// ===== verification/tb_top.sv
// self-checking bench for the serial-to-parallel driver logic
`timescale 1ns/10ps
module tb_top;
  typedef struct {logic [15:0] d; logic p; logic [15:0] q; logic b;} spd_row_t;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic gate_n = 1'b0;
  logic pol_n = 1'b1;
  wire sclk, sdin, so, bp, known, rate_err;
  wire [15:0] hso;
  integer n_fail = 0;
  integer n_tests = 0;
  integer i;
  spd_row_t rows [3];
  always #4 clk = ~clk;
  spd_host_model spd_host_model_inst (.clk_i(clk), .sclk_o(sclk), .dat_o(sdin));
  spd_driver_logic spd_driver_logic_inst (.clk_i(clk), .arst_n_i(arst_n),
    .shift_clk_i(sclk), .serial_in_i(sdin), .latch_gate_n_i(gate_n),
    .invert_select_n_i(pol_n), .serial_out_o(so), .high_side_outputs_o(hso),
    .backplane_drive_o(bp), .contents_known_o(known),
    .shift_rate_error_o(rate_err));
  ////////////////////////////////////////////////////////////////////////////
  task chk16(input string n, input logic [15:0] e, input logic [15:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        n_fail++;
        $display("unexpected %s: expected %h seen %h", n, e, g);
      end
    end
  endtask
  task chk1(input string n, input logic e, input logic g);
    begin
      chk16(n, {15'h0000, e}, {15'h0000, g});
    end
  endtask
  // registered outputs need one edge, so allow two
  task settle;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows[0] = '{16'hA5C3, 1'b1, 16'hA5C3, 1'b0};
    rows[1] = '{16'h0F01, 1'b0, 16'hF0FE, 1'b1};
    rows[2] = '{16'h8000, 1'b1, 16'h8000, 1'b0};
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    settle();
    chk16("outputs", 16'h0000, hso);
    chk1("known", 1'b0, known);
    $display("reset test done");
    for (i = 0; i < 3; i++)
    begin
      @(posedge clk);
      pol_n <= rows[i].p;
      spd_host_model_inst.shift_word(rows[i].d);
      settle();
      chk16("outputs", rows[i].q, hso);
      chk1("backplane", rows[i].b, bp);
      chk1("serial out", rows[i].d[15], so);
      $display("row %0d done", i);
    end
    @(posedge clk);
    gate_n <= 1'b1;
    spd_host_model_inst.shift_word(16'h3C5A);
    settle();
    chk16("outputs", 16'h8000, hso);
    chk1("serial out", 1'b0, so);
    $display("freeze test done");
    @(posedge clk);
    pol_n <= 1'b0;
    settle();
    chk16("outputs", 16'h7FFF, hso);
    chk1("backplane", 1'b1, bp);
    $display("polarity test done");
    @(posedge clk);
    gate_n <= 1'b0;
    settle();
    chk16("outputs", 16'hC3A5, hso);
    chk1("known", 1'b1, known);
    chk1("rate error", 1'b0, rate_err);
    $display("release test done");
    // a long idle saturates the rate counters, which must not wrap
    repeat (600) @(posedge clk);
    spd_host_model_inst.clock_pulse(130);
    settle();
    chk1("rate error", 1'b0, rate_err);
    spd_host_model_inst.clock_pulse(10);
    settle();
    chk1("rate error", 1'b1, rate_err);
    $display("rate test done");
    close_out();
  end
endmodule // tb_top
